// *** bench/cic_cpu_model.sv ***
// sequencer stand-in: instruction ticks and a live working register
`timescale 1ns/100ps
module cic_cpu_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       restore_ctx,
	input  wire logic [7:0] shadow_w,
	output logic            tcy_tick,
	output logic [7:0]      live_w
);
	logic [1:0] q_reg;
	always_ff @(posedge clk) begin
		q_reg <= rst ? 2'h0 : q_reg + 2'h1;
		tcy_tick <= !rst && q_reg == 2'h2;
	end
	always_ff @(posedge clk) begin
		if (rst)
			live_w <= 8'h5A;
		else if (restore_ctx)
			live_w <= shadow_w;
		else if (tcy_tick)
			live_w <= live_w + 8'h01;
	end
endmodule // cic_cpu_model

// *** bench/cic_ctrl_bench.sv ***
// self-checking bench for the interrupt control block
`timescale 1ns/100ps
module cic_ctrl_bench;
	import cic_pkg::*;
	logic        clk = 1'h0, rst = 1'h1, rd = 1'h0, wr = 1'h0, pin = 1'h1, tmr = 1'h0;
	logic        chg = 1'h0, per = 1'h0, slp = 1'h0, ret = 1'h0, wq, tk, psh, ldv, pop, rs;
	logic        wk, hit;
	logic [7:0]  ad = 8'h00, lw, sw;
	logic [31:0] wd = 32'h0, rdat, rv;
	logic [7:0]        sst;
	logic [BSR_W-1:0]  sbs;
	logic [FSR_W-1:0]  sf0, sf1;
	logic [PCL_W-1:0]  spc;
	logic [PC_W-1:0]   vad;
	int          n_fail = 0, num_checks = 0, cyc = 0, n;
	always #12.5 clk = ~clk;
	cic_ctrl uut (.clk(clk), .rst(rst), .avs_address(ad), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wq), .tcy_tick(tk),
		.ext_pin(pin), .timer_zero_overflow_event(tmr), .per_pin_change_any(chg),
		.periph_irq_pending(per), .cpu_sleeping(slp), .return_from_irq_instr(ret),
		.live_w(lw), .live_status(~lw), .live_bsr(5'h0A), .live_fsr0(16'h1234),
		.live_fsr1(16'h5678), .live_pc_high_latch(7'h15), .irq_flush(), .push_return(psh),
		.load_vector(ldv), .vector_addr(vad), .pop_return(pop), .restore_ctx(rs),
		.wake_up(wk), .global_irq_enable(), .shadow_w(sw), .shadow_status(sst),
		.shadow_bsr(sbs), .shadow_fsr0(sf0), .shadow_fsr1(sf1), .shadow_pc_high_latch(spc));
	cic_cpu_model u_cpu (.clk(clk), .rst(rst), .restore_ctx(rs), .shadow_w(sw),
		.tcy_tick(tk), .live_w(lw));
	task automatic chk(input logic [31:0] got, exp, input string nm);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// request held until waitrequest is seen low
	task automatic bus(input logic [7:0] a, input logic [31:0] d = 32'h0, input logic w = 1'h0);
		ad <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		while (wq !== 1'h0)
			@(posedge clk);
		rv = rdat;
		wr <= 1'h0;
		rd <= 1'h0;
		@(posedge clk);
	endtask
	task automatic watch(input int c);
		hit = 1'h0;
		repeat (c) begin
			@(posedge clk);
			hit = hit | (psh === 1'h1);
		end
	endtask
	task automatic kick();
		tmr <= 1'h1;
		@(posedge clk);
		tmr <= 1'h0;
	endtask
	task automatic do_ret();
		ret <= 1'h1;
		@(posedge clk);
		ret <= 1'h0;
		@(posedge clk);
		chk(pop, 1'h1, "pop_return");
	endtask
	task automatic t_regs();
		bus(OFS_CTRL);
		chk(rv, 32'h0, "ctrl reset");
		bus(OFS_STATE);
		chk(rv, {24'h0, SHADOW_BANK, 3'h1}, "shadow bank");
		bus(8'h30);
		chk(rv, 32'h0, "unmapped");
		kick();
		chg <= 1'h1;
		watch(8);
		chk(hit, 1'h0, "entry while disabled");
		bus(OFS_CTRL);
		chk(rv, 32'h05, "flags set");
		bus(OFS_CTRL, 32'h0, 1'h1);
		bus(OFS_CTRL);
		chk(rv, 32'h01, "flags after zero write");
		chg <= 1'h0;
		watch(3);
		bus(OFS_CTRL);
		chk(rv, 32'h0, "summary clears");
		// an overflow stands at the very edge at which a zero write clears the flag
		tmr <= 1'h1;
		ad <= OFS_CTRL;
		wd <= 32'h0;
		wr <= 1'h1;
		@(posedge clk);
		while (wq !== 1'h0)
			@(posedge clk);
		wr <= 1'h0;
		tmr <= 1'h0;
		@(posedge clk);
		bus(OFS_CTRL);
		chk(rv[T0IF_BIT], 1'h1, "set wins over clear");
		$display("register test done");
	endtask
	// tick phase is swept so both latency cases occur
	task automatic t_lat();
		for (int k = 0; k < 4; k++) begin
			bus(OFS_CTRL, 32'hA0, 1'h1);
			repeat (k) @(posedge clk);
			kick();
			n = 0;
			for (int i = 0; i < 30 && ldv !== 1'h1; i++) begin
				n += int'(tk === 1'h1);
				@(posedge clk);
			end
			chk(n == 2 || n == 3, 1'h1, "vector latency");
			chk(vad, VECTOR_ADDR, "vector address");
			chk(sst, ~sw & STAT_SAVE, "status shadow");
			chk({sbs, spc}, {5'h0A, 7'h15}, "bank and latch shadows");
			chk({sf0, sf1}, 32'h12345678, "file select shadows");
			bus(OFS_SH_W, 32'h3C, 1'h1);
			chk(sw, 8'h3C, "shadow written");
			bus(OFS_CTRL, 32'h20, 1'h1);
			do_ret();
			@(posedge clk);
			chk(lw, 8'h3C, "context restored");
		end
		$display("latency test done");
	endtask
	task automatic t_wake();
		bus(OFS_CTRL, 32'h0, 1'h1);
		slp <= 1'h1;
		kick();
		watch(4);
		chk(wk, 1'h0, "no wake while disabled");
		slp <= 1'h0;
		bus(OFS_CTRL, 32'h20, 1'h1);
		slp <= 1'h1;
		kick();
		watch(4);
		chk(wk, 1'h1, "wake");
		slp <= 1'h0;
		watch(16);
		chk(hit, 1'h0, "no branch without enable");
		slp <= 1'h1;
		bus(OFS_CTRL, 32'hA0, 1'h1);
		kick();
		watch(4);
		chk(wk, 1'h1, "wake with global enable");
		slp <= 1'h0;
		// one tick ends the instruction after sleep, the next one takes the entry
		n = 0;
		for (int i = 0; i < 30 && psh !== 1'h1; i++) begin
			@(posedge clk);
			n += int'(tk === 1'h1);
		end
		chk(psh, 1'h1, "branch after wake");
		chk(n, 2, "one instruction before branch");
		$display("wake test done");
	endtask
	task automatic t_ext();
		for (int e = 0; e < 2; e++) begin
			bus(OFS_OPTION, e, 1'h1);
			pin <= !e;
			watch(6);
			for (int p = 0; p < 2; p++) begin
				bus(OFS_CTRL, 32'h90, 1'h1);
				pin <= (e != p);
				watch(12);
				chk(hit, !p, "pin redirect");
				bus(OFS_CTRL);
				chk(rv[1], !p, "pin flag");
			end
		end
		$display("pin test done");
	endtask
	task automatic t_peri();
		per <= 1'h1;
		bus(OFS_CTRL, 32'h80, 1'h1);
		watch(12);
		chk(hit, 1'h0, "peripheral gated");
		bus(OFS_CTRL, 32'hC0, 1'h1);
		watch(12);
		chk(hit, 1'h1, "peripheral taken");
		per <= 1'h0;
		$display("peripheral test done");
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_regs();
		t_lat();
		t_wake();
		t_ext();
		t_peri();
		end_of_test();
	end
endmodule // cic_ctrl_bench

// *** bench/cic_ctrl_monitor.sv ***
// assertion checker bound to the interrupt control block
`timescale 1ns/100ps
module cic_ctrl_monitor
	import cic_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest,
	input wire logic       tcy_tick,
	input wire logic       return_from_irq_instr,
	input wire logic [7:0] live_w,
	input wire logic       irq_flush,
	input wire logic       push_return,
	input wire logic       load_vector,
	input wire logic       pop_return,
	input wire logic       restore_ctx,
	input wire logic       global_irq_enable,
	input wire logic [7:0] shadow_w
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_bus; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_bus: assert property (p_bus) else $error("bus answer late");
	property p_ent; push_return |-> irq_flush && !global_irq_enable; endproperty
	a_ent: assert property (p_ent) else $error("entry state wrong");
	property p_why; push_return |-> $past(tcy_tick) && $past(global_irq_enable); endproperty
	a_why: assert property (p_why) else $error("entry without cause");
	property p_save; push_return |-> shadow_w == $past(live_w); endproperty
	a_save: assert property (p_save) else $error("context not saved");
	property p_vec; push_return |-> ##[1:12] load_vector; endproperty
	a_vec: assert property (p_vec) else $error("vector not loaded");
	property p_load; load_vector |-> $past(irq_flush) && !irq_flush; endproperty
	a_load: assert property (p_load) else $error("flush span wrong");
	property p_ret; pop_return |-> restore_ctx && global_irq_enable && $past(return_from_irq_instr);
	endproperty
	a_ret: assert property (p_ret) else $error("return wrong");
	property p_rise;
		$rose(global_irq_enable) |-> pop_return || $past(avs_write && !avs_waitrequest);
	endproperty
	a_rise: assert property (p_rise) else $error("enable set unasked");
endmodule // cic_ctrl_monitor

bind cic_ctrl cic_ctrl_monitor u_mon (.*);

// *** core/cic_ctrl.sv ***
// interrupt control: flags, enables, entry sequence, context shadows, bus slave
`timescale 1ns/100ps
// Operation
// R1: synchronous event reaches vector in 3-4 cycles
// R2: asynchronous event reaches vector in 3-5 cycles
// R3: latency independent of instruction length
// R4: external flag set across Q4 to Q1
// R5: only enabled clockless sources wake from sleep
// R6: wake branches to vector only if global enabled
// R7: one instruction after sleep runs before branch
// R8: external pin gives edge-triggered enabled interrupt
// R9: edge select one rising, zero falling
// R10: valid edge sets flag, redirects if enabled
// R11: entry pushes return, saves core registers
// R12: exit reloads registers from shadows
// R13: shadows in top bank, software readable writable
// R14: peripheral enable gates all peripheral sources
// R15: external flag at bit one reads set
// R16: change summary flag read-only, self clearing
// R17: flags set regardless of any enable
// R18: entry flushes, clears global, loads vector
// R19: return pops, restores, sets global enable
// R20: writable flags cleared by zero, set wins
module cic_ctrl
	import cic_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic [ADDR_W-1:0]   avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [DATA_W-1:0]   avs_writedata,
	output logic      [DATA_W-1:0]   avs_readdata,
	output logic                     avs_waitrequest,
	input  wire logic                tcy_tick,
	input  wire logic                ext_pin,
	input  wire logic                timer_zero_overflow_event,
	input  wire logic                per_pin_change_any,
	input  wire logic                periph_irq_pending,
	input  wire logic                cpu_sleeping,
	input  wire logic                return_from_irq_instr,
	input  wire logic [7:0]          live_w,
	input  wire logic [7:0]          live_status,
	input  wire logic [BSR_W-1:0]    live_bsr,
	input  wire logic [FSR_W-1:0]    live_fsr0,
	input  wire logic [FSR_W-1:0]    live_fsr1,
	input  wire logic [PCL_W-1:0]    live_pc_high_latch,
	output logic                     irq_flush,
	output logic                     push_return,
	output logic                     load_vector,
	output logic      [PC_W-1:0]     vector_addr,
	output logic                     pop_return,
	output logic                     restore_ctx,
	output logic                     wake_up,
	output logic                     global_irq_enable,
	output logic      [7:0]          shadow_w,
	output logic      [7:0]          shadow_status,
	output logic      [BSR_W-1:0]    shadow_bsr,
	output logic      [FSR_W-1:0]    shadow_fsr0,
	output logic      [FSR_W-1:0]    shadow_fsr1,
	output logic      [PCL_W-1:0]    shadow_pc_high_latch
);
	logic [7:0]   ctrl_reg;
	logic         edge_sel_reg;
	logic         sync1_reg;
	logic         sync2_reg;
	logic         sync3_reg;
	logic         wait_reg;
	logic         hold_reg;
	logic         wake_reg;
	cic_state_t   state_reg;
	logic         wr_fire;
	logic         rd_fire;
	logic         ext_edge;
	logic         src_pending;
	logic         take;
	logic         entering;
	logic         return_from_irq_instr_go;
	logic [DATA_W-1:0] rd_mux;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// the answer comes one cycle after the request; write acts at the same edge read data is taken
	assign wr_fire = avs_write && !wait_reg;
	assign rd_fire = avs_read && !wait_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			wait_reg <= 1'b1;
		end else if ((avs_read || avs_write) && wait_reg) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= 1'b1;
		end
	end
	assign avs_waitrequest = wait_reg;

	// R2: asynchronous pin retimed here
	// kept out of reset: the chain tracks the pin while reset is held,
	// so the release of reset shows no false edge
	// second flop feeds the edge detector and the third flop, first flop only the second
	always_ff @(posedge clk) begin
		sync1_reg <= ext_pin;
		sync2_reg <= sync1_reg;
		sync3_reg <= sync2_reg;
	end

	// R8: pin edge is the external source
	// R9: edge polarity select
	assign ext_edge = edge_sel_reg ? (sync2_reg && !sync3_reg) : (!sync2_reg && sync3_reg);

	// R14: peripheral gate
	assign src_pending = (ctrl_reg[T0IE_BIT] && ctrl_reg[T0IF_BIT])
		|| (ctrl_reg[EXTIE_BIT] && ctrl_reg[EXTIF_BIT])
		|| (ctrl_reg[CNIE_BIT] && ctrl_reg[CNIF_BIT])
		|| (ctrl_reg[PERIPHERAL_IRQ_ENABLE_BIT] && periph_irq_pending);

	// R3: entry decided only on instruction cycle boundaries
	// R10: redirect needs global and source enables
	assign take      = tcy_tick && (state_reg == CIC_IDLE) && ctrl_reg[GIE_BIT] && src_pending
		&& !hold_reg && !cpu_sleeping;
	assign entering  = take;
	assign return_from_irq_instr_go = return_from_irq_instr && (state_reg == CIC_IDLE);

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg <= CTRL_RST;
		end else begin
			if (wr_fire && hit(avs_address, OFS_CTRL)) begin
				ctrl_reg[7:3] <= avs_writedata[7:3];
				// R20: zero clears, an event in the same cycle wins
				ctrl_reg[T0IF_BIT]  <= avs_writedata[T0IF_BIT] || timer_zero_overflow_event
					|| ctrl_reg[T0IF_BIT] && avs_writedata[T0IF_BIT];
				ctrl_reg[EXTIF_BIT] <= avs_writedata[EXTIF_BIT] || ext_edge;
			end else begin
				// R17: flags set whatever the enables
				if (timer_zero_overflow_event) begin
					ctrl_reg[T0IF_BIT] <= 1'b1;
				end
				// R4: flag set as soon as the synchronised edge is seen
				// R15: external flag bit one
				if (ext_edge) begin
					ctrl_reg[EXTIF_BIT] <= 1'b1;
				end
			end
			// R16: summary follows the per-pin flags, never written
			ctrl_reg[CNIF_BIT] <= per_pin_change_any;
			// R18: entry clears global enable
			if (entering) begin
				ctrl_reg[GIE_BIT] <= 1'b0;
			end else if (return_from_irq_instr_go) begin
				// R19: return re-enables
				ctrl_reg[GIE_BIT] <= 1'b1;
			end
		end
	end
	assign global_irq_enable = ctrl_reg[GIE_BIT];

	always_ff @(posedge clk) begin
		if (rst) begin
			edge_sel_reg <= EDGE_RST;
		end else if (wr_fire && hit(avs_address, OFS_OPTION)) begin
			edge_sel_reg <= avs_writedata[EDGE_BIT];
		end
	end

	// R5: wake needs the source enable, not the global one
	always_ff @(posedge clk) begin
		if (rst) begin
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= cpu_sleeping && src_pending;
		end
	end
	assign wake_up = wake_reg;

	// R7: after a wake one instruction cycle passes before entry
	// R6: with global enable clear the pending source is simply not taken
	always_ff @(posedge clk) begin
		if (rst) begin
			hold_reg <= 1'b0;
		end else if (cpu_sleeping) begin
			hold_reg <= 1'b1;
		end else if (tcy_tick) begin
			hold_reg <= 1'b0;
		end
	end

	// R1: flag cycle plus flush and vector cycles gives 3-4
	// R2: two synchroniser stages add the extra cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= CIC_IDLE;
		end else begin
			unique case (state_reg)
				CIC_IDLE: begin
					if (take) begin
						state_reg <= CIC_FLUSH;
					end
				end
				CIC_FLUSH: begin
					if (tcy_tick) begin
						state_reg <= CIC_VECT;
					end
				end
				CIC_VECT: begin
					if (tcy_tick) begin
						state_reg <= CIC_IDLE;
					end
				end
			endcase
		end
	end

	// R18: flush, push, vector load
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_flush   <= 1'b0;
			push_return <= 1'b0;
			load_vector <= 1'b0;
			vector_addr <= VECTOR_ADDR;
			pop_return  <= 1'b0;
			restore_ctx <= 1'b0;
		end else begin
			irq_flush   <= entering || (state_reg == CIC_FLUSH && !tcy_tick);
			push_return <= entering;
			load_vector <= (state_reg == CIC_FLUSH) && tcy_tick;
			vector_addr <= VECTOR_ADDR;
			// R19: pop return address
			pop_return  <= return_from_irq_instr_go;
			// R12: restore from shadows on exit
			restore_ctx <= return_from_irq_instr_go;
		end
	end

	// R11: capture live context on entry; capture outranks a bus write
	// R13: shadows writable by software
	always_ff @(posedge clk) begin
		if (rst) begin
			shadow_w      <= '0;
			shadow_status <= '0;
			shadow_bsr    <= '0;
			shadow_fsr0   <= '0;
			shadow_fsr1   <= '0;
			shadow_pc_high_latch <= '0;
		end else if (entering) begin
			shadow_w      <= live_w;
			shadow_status <= live_status & STAT_SAVE;
			shadow_bsr    <= live_bsr;
			shadow_fsr0   <= live_fsr0;
			shadow_fsr1   <= live_fsr1;
			shadow_pc_high_latch <= live_pc_high_latch;
		end else if (wr_fire) begin
			if (hit(avs_address, OFS_SH_W)) begin
				shadow_w <= avs_writedata[7:0];
			end
			if (hit(avs_address, OFS_SH_STAT)) begin
				shadow_status <= avs_writedata[7:0] & STAT_SAVE;
			end
			if (hit(avs_address, OFS_SH_BSR)) begin
				shadow_bsr <= avs_writedata[BSR_W-1:0];
			end
			if (hit(avs_address, OFS_SH_FSR0)) begin
				shadow_fsr0 <= avs_writedata[FSR_W-1:0];
			end
			if (hit(avs_address, OFS_SH_FSR1)) begin
				shadow_fsr1 <= avs_writedata[FSR_W-1:0];
			end
			if (hit(avs_address, OFS_SH_PCL)) begin
				shadow_pc_high_latch <= avs_writedata[PCL_W-1:0];
			end
		end
	end

	always_comb begin
		rd_mux = '0;
		unique case (avs_address)
			OFS_CTRL:    rd_mux[7:0] = ctrl_reg;
			OFS_OPTION:  rd_mux[EDGE_BIT] = edge_sel_reg;
			OFS_SH_W:    rd_mux[7:0] = shadow_w;
			OFS_SH_STAT: rd_mux[7:0] = shadow_status;
			OFS_SH_BSR:  rd_mux[BSR_W-1:0] = shadow_bsr;
			OFS_SH_FSR0: rd_mux[FSR_W-1:0] = shadow_fsr0;
			OFS_SH_FSR1: rd_mux[FSR_W-1:0] = shadow_fsr1;
			OFS_SH_PCL:  rd_mux[PCL_W-1:0] = shadow_pc_high_latch;
			OFS_STATE:   rd_mux[7:0] = {SHADOW_BANK, state_reg};
			default:     rd_mux = '0;
		endcase
	end

	// read data is loaded on the edge that lowers waitrequest and stands in that cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			avs_readdata <= '0;
		end else if (avs_read && wait_reg) begin
			avs_readdata <= rd_mux;
		end
	end
endmodule // cic_ctrl

// *** core/cic_pkg.sv ***
// constants shared by the interrupt control block
package cic_pkg;
	localparam int          DATA_W      = 32;
	localparam int          ADDR_W      = 8;
	localparam int          PC_W        = 15;
	// register byte addresses on the slave bus
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_OPTION  = 8'h04;
	localparam logic [7:0]  OFS_SH_W    = 8'h08;
	localparam logic [7:0]  OFS_SH_STAT = 8'h0C;
	localparam logic [7:0]  OFS_SH_BSR  = 8'h10;
	localparam logic [7:0]  OFS_SH_FSR0 = 8'h14;
	localparam logic [7:0]  OFS_SH_FSR1 = 8'h18;
	localparam logic [7:0]  OFS_SH_PCL  = 8'h1C;
	localparam logic [7:0]  OFS_STATE   = 8'h20;
	// interrupt_control fields
	localparam int          GIE_BIT     = 7;
	localparam int          PERIPHERAL_IRQ_ENABLE_BIT    = 6;
	localparam int          T0IE_BIT    = 5;
	localparam int          EXTIE_BIT   = 4;
	localparam int          CNIE_BIT    = 3;
	localparam int          T0IF_BIT    = 2;
	localparam int          EXTIF_BIT   = 1;
	localparam int          CNIF_BIT    = 0;
	localparam logic [7:0]  CTRL_RST    = 8'h00;
	// option register: edge select of the external pin
	localparam int          EDGE_BIT    = 0;
	localparam logic        EDGE_RST    = 1'b0;
	// timeout and power-down status bits are never shadowed
	localparam logic [7:0]  STAT_SAVE   = 8'hE7;
	localparam logic [PC_W-1:0] VECTOR_ADDR = 15'h0004;
	localparam logic [4:0]  SHADOW_BANK = 5'h1F;
	localparam int          BSR_W       = 5;
	localparam int          PCL_W       = 7;
	localparam int          FSR_W       = 16;
	typedef enum logic [2:0] {
		CIC_IDLE  = 3'b001,
		CIC_FLUSH = 3'b010,
		CIC_VECT  = 3'b100
	} cic_state_t;
endpackage
